/* File: verilog/uart_pkg.sv */
/*
  Shared constants and carrier types for the asynchronous serial port.
  Assumes a single core clock; no bus, all controls are plain ports.
*/
package uart_pkg;
  localparam int CORE_CLK_MHZ    = 100;
  localparam int OVERSAMPLE      = 16;
  localparam int T1_RELOAD_SPAN  = 256;
  localparam int T2_RELOAD_SPAN  = 65536;
  localparam int T1_DIV_FAST     = 4;
  localparam int T1_DIV_SLOW     = 12;
  localparam int T2_BAUD_DIV     = 2;
  localparam int FIXED_DIV_SLOW  = 64;
  localparam int FIXED_DIV_FAST  = 32;
  localparam int TX_DONE_DELAY   = 2;
  localparam int VOTE_FIRST      = 7;
  localparam int VOTE_LAST       = 9;
  localparam logic [7:0]  T1_MAX = 8'hff;
  localparam logic [15:0] T2_MAX = 16'hffff;
  localparam logic        LINE_IDLE = 1'b1;

  typedef enum logic [1:0] {
    MODE_SHIFT,
    MODE_ASYNC8,
    MODE_ASYNC9_FIXED,
    MODE_ASYNC9_TIMER
  } uart_mode_e;

  typedef struct packed {
    logic [1:0] mode;
    logic       multiprocEnable;
    logic       receiveEnable;
    logic       txNinthBit;
    logic       baudDouble;
    logic       timer1Div4Select;
    logic       txTimer2Select;
    logic       rxTimer2Select;
  } uart_cfg_s;

  typedef struct packed {
    logic [7:0] timer1ReloadByte;
    logic [7:0] timer2ReloadHigh;
    logic [7:0] timer2ReloadLow;
  } uart_reload_s;
endpackage

/* File: verilog/baud_tick_gen.sv */
/*
  Baud tick source: Timer 1 auto-reload, Timer 2 baud mode and the fixed
  divider, each giving one 16x oversample tick per bit sixteenth.
  Assumes reload values are held stable by software while in use.
*/
`timescale 1ns/10ps
module baud_tick_gen
(
  input  wire logic                  core_clk,    // Core clock
  input  wire logic                  reset_n,     // Async reset
  input  wire uart_pkg::uart_cfg_s   cfg,         // Port configuration
  input  wire uart_pkg::uart_reload_s reload,     // Reload values
  input  wire logic                  t2ExtTrig,   // Timer 2 trigger, sets flag when not in baud use
  output logic                       txTick,      // Tx oversample tick
  output logic                       rxTick,      // Rx oversample tick
  output logic                       timer2OverflowFlag // Timer 2 flag
);
  logic [3:0]  pre1_ff, nxt_pre1;
  logic        pre2_ff, nxt_pre2;
  logic [7:0]  t1_ff, nxt_t1;
  logic [15:0] t2_ff, nxt_t2;
  logic        half_ff, nxt_half;
  logic [1:0]  fix_ff, nxt_fix;
  logic        tf2_ff, nxt_tf2;
  logic        t1Roll, t2Roll, t1Tick, fixTick, t2On;
  logic [3:0]  pre1Last;

  assign t2On = cfg.txTimer2Select | cfg.rxTimer2Select;
  assign pre1Last = cfg.timer1Div4Select ? 4'(uart_pkg::T1_DIV_FAST - 1)
                                         : 4'(uart_pkg::T1_DIV_SLOW - 1);

  always_comb
  begin
    nxt_pre1 = (pre1_ff >= pre1Last) ? 4'h0 : pre1_ff + 4'h1;
    nxt_pre2 = ~pre2_ff;
    nxt_t1   = t1_ff;
    nxt_t2   = t2_ff;
    nxt_half = half_ff;
    nxt_fix  = fix_ff + 2'h1;
    nxt_tf2  = tf2_ff;
    t1Roll   = 1'b0;
    t2Roll   = 1'b0;
    if (pre1_ff == pre1Last)
    begin
      t1Roll = (t1_ff == uart_pkg::T1_MAX);
      nxt_t1 = t1Roll ? reload.timer1ReloadByte : t1_ff + 8'h01;
    end
    if (t2On && pre2_ff)
    begin
      t2Roll = (t2_ff == uart_pkg::T2_MAX);
      nxt_t2 = t2Roll ? {reload.timer2ReloadHigh, reload.timer2ReloadLow}
                      : t2_ff + 16'h0001;
    end
    // Other timer 2 modes not modelled; parked at reload so baud use
    // starts at once instead of after a full 16-bit wrap
    if (!t2On)
      nxt_t2 = {reload.timer2ReloadHigh, reload.timer2ReloadLow};
    if (!t2On && t2ExtTrig)
      nxt_tf2 = 1'b1;
    if (t1Roll)
      nxt_half = ~half_ff;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pre1_ff <= 4'h0;
      pre2_ff <= 1'b0;
      t1_ff   <= 8'h00;
      t2_ff   <= 16'h0000;
      half_ff <= 1'b0;
      fix_ff  <= 2'h0;
      tf2_ff  <= 1'b0;
    end
    else
    begin
      pre1_ff <= nxt_pre1;
      pre2_ff <= nxt_pre2;
      t1_ff   <= nxt_t1;
      t2_ff   <= nxt_t2;
      half_ff <= nxt_half;
      fix_ff  <= nxt_fix;
      tf2_ff  <= nxt_tf2;
    end
  end

  assign t1Tick  = t1Roll & (cfg.baudDouble | half_ff);
  // clk/4 per sixteenth, clk/2 with double
  assign fixTick = cfg.baudDouble ? fix_ff[0] : (fix_ff == 2'h3);
  assign timer2OverflowFlag = tf2_ff;

  always_comb
  begin
    txTick = 1'b0;
    rxTick = 1'b0;
    case (uart_pkg::uart_mode_e'(cfg.mode))
      uart_pkg::MODE_ASYNC9_FIXED:
      begin
        txTick = fixTick;
        rxTick = fixTick;
      end
      uart_pkg::MODE_ASYNC8, uart_pkg::MODE_ASYNC9_TIMER:
      begin
        txTick = cfg.txTimer2Select ? t2Roll : t1Tick;
        rxTick = cfg.rxTimer2Select ? t2Roll : t1Tick;
      end
      default:
      begin
        txTick = 1'b0;
        rxTick = 1'b0;
      end
    endcase
  end
endmodule

/* File: verilog/async_serial_port.sv */
/*
  Asynchronous serial port, modes 1 to 3, with multiprocessor addressing.
  Assumes software clears the done flags; rxd pin is asynchronous.
*/
`timescale 1ns/10ps
module async_serial_port
(
  input  wire logic                   core_clk,      // 100 MHz clock
  input  wire logic                   reset_n,       // Async reset
  input  wire uart_pkg::uart_cfg_s    cfg,           // Control bits
  input  wire uart_pkg::uart_reload_s reload,        // Timer reloads
  input  wire logic                   timer2ExtTrigger, // Timer 2 trigger
  input  wire logic                   bufWrite,      // Data buffer write
  input  wire logic [7:0]             bufWriteData,  // Byte to send
  input  wire logic                   clearTxDone,   // Clear tx flag
  input  wire logic                   clearRxDone,   // Clear rx flag
  input  wire logic                   rxdPin,        // Receive pin
  output logic                        txdPin,        // Transmit pin
  output logic [7:0]                  serialDataBuffer, // Received byte
  output logic                        rxNinthBit,    // Received 9th bit
  output logic                        transmitDoneFlag, // Tx done
  output logic                        receiveDoneFlag,  // Rx done
  output logic                        timer2OverflowFlag, // Timer 2 flag
  output logic                        serialIrq      // Interrupt request
);
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SHIFT, TX_DONE} tx_st_e;
  typedef enum logic [1:0] {RX_IDLE, RX_FRAME} rx_st_e;

  logic txTick, rxTick, ninth;
  logic rxSync1_ff, rxSync2_ff, rxPrev_ff;

  baud_tick_gen u_baud
  (
    .core_clk          (core_clk),
    .reset_n           (reset_n),
    .cfg               (cfg),
    .reload            (reload),
    .t2ExtTrig         (timer2ExtTrigger),
    .txTick            (txTick),
    .rxTick            (rxTick),
    .timer2OverflowFlag(timer2OverflowFlag)
  );

  assign ninth = cfg.mode[1];

  // Transmitter
  tx_st_e      txSt_ff, nxt_txSt;
  logic [3:0]  txDiv_ff, nxt_txDiv;
  logic [10:0] txShift_ff, nxt_txShift;
  logic [3:0]  txBits_ff, nxt_txBits;
  logic [1:0]  txDly_ff, nxt_txDly;
  logic        txd_ff, nxt_txd;
  logic        ti_ff, nxt_ti;
  logic        txRoll, setTi;

  assign txRoll = txTick && (txDiv_ff == 4'hf);

  always_comb
  begin
    nxt_txSt    = txSt_ff;
    nxt_txDiv   = txTick ? txDiv_ff + 4'h1 : txDiv_ff;
    nxt_txShift = txShift_ff;
    nxt_txBits  = txBits_ff;
    nxt_txDly   = txDly_ff;
    nxt_txd     = txd_ff;
    setTi       = 1'b0;
    case (txSt_ff)
      TX_IDLE:
      begin
        nxt_txd = uart_pkg::LINE_IDLE;
        if (bufWrite && cfg.mode != 2'b00)
        begin
          nxt_txShift = ninth ? {1'b1, cfg.txNinthBit, bufWriteData, 1'b0}
                              : {2'b11, bufWriteData, 1'b0};
          nxt_txBits  = ninth ? 4'd11 : 4'd10;
          nxt_txSt    = TX_WAIT;
        end
      end
      TX_WAIT:
        if (txRoll)
        begin
          nxt_txd     = txShift_ff[0];
          nxt_txShift = {1'b1, txShift_ff[10:1]};
          nxt_txBits  = txBits_ff - 4'h1;
          nxt_txSt    = TX_SHIFT;
        end
      TX_SHIFT:
        if (txRoll)
        begin
          nxt_txd     = txShift_ff[0];
          nxt_txShift = {1'b1, txShift_ff[10:1]};
          nxt_txBits  = txBits_ff - 4'h1;
          if (txBits_ff == 4'h1)
          begin
            setTi     = ninth;
            nxt_txDly = 2'(uart_pkg::TX_DONE_DELAY);
            nxt_txSt  = ninth ? TX_IDLE : TX_DONE;
          end
        end
      TX_DONE:
      begin
        nxt_txDly = txDly_ff - 2'h1;
        if (txDly_ff <= 2'h1)
        begin
          setTi     = 1'b1;
          nxt_txDly = 2'h0;
          nxt_txSt  = TX_IDLE;
        end
      end
      default:
        nxt_txSt = TX_IDLE;
    endcase
    nxt_ti = setTi | (ti_ff & ~clearTxDone);
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      txSt_ff    <= TX_IDLE;
      txDiv_ff   <= 4'h0;
      txShift_ff <= 11'h7ff;
      txBits_ff  <= 4'h0;
      txDly_ff   <= 2'h0;
      txd_ff     <= 1'b1;
      ti_ff      <= 1'b0;
    end
    else
    begin
      txSt_ff    <= nxt_txSt;
      txDiv_ff   <= nxt_txDiv;
      txShift_ff <= nxt_txShift;
      txBits_ff  <= nxt_txBits;
      txDly_ff   <= nxt_txDly;
      txd_ff     <= nxt_txd;
      ti_ff      <= nxt_ti;
    end
  end

  // Receiver; pin synchronised before any use
  rx_st_e     rxSt_ff, nxt_rxSt;
  logic [3:0] rxDiv_ff, nxt_rxDiv;
  logic [1:0] vote_ff, nxt_vote;
  logic [9:0] rxShift_ff, nxt_rxShift;
  logic [3:0] rxBits_ff, nxt_rxBits;
  logic [7:0] serial_data_buffer_ff, nxt_serial_data_buffer;
  logic       rb8_ff, nxt_rb8;
  logic       ri_ff, nxt_ri;
  logic       bitVal, setRi, fallEdge, stopBit, gotNinth;
  logic [3:0] frameBits;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rxSync1_ff <= 1'b1;
      rxSync2_ff <= 1'b1;
      rxPrev_ff  <= 1'b1;
    end
    else
    begin
      rxSync1_ff <= rxdPin;
      rxSync2_ff <= rxSync1_ff;
      rxPrev_ff  <= rxSync2_ff;
    end
  end

  assign fallEdge  = rxPrev_ff & ~rxSync2_ff;
  assign frameBits = ninth ? 4'd11 : 4'd10;
  // two of three
  // Live sample is the third, so all three belong to this bit
  assign bitVal = (vote_ff[0] & vote_ff[1]) | (vote_ff[1] & rxSync2_ff)
                | (vote_ff[0] & rxSync2_ff);
  assign stopBit  = bitVal;
  assign gotNinth = rxShift_ff[9];

  always_comb
  begin
    nxt_rxSt    = rxSt_ff;
    nxt_rxDiv   = rxTick ? rxDiv_ff + 4'h1 : rxDiv_ff;
    nxt_vote    = vote_ff;
    nxt_rxShift = rxShift_ff;
    nxt_rxBits  = rxBits_ff;
    nxt_serial_data_buffer    = serial_data_buffer_ff;
    nxt_rb8     = rb8_ff;
    setRi       = 1'b0;
    if (rxTick && rxDiv_ff >= 4'(uart_pkg::VOTE_FIRST)
        && rxDiv_ff <= 4'(uart_pkg::VOTE_LAST))
      nxt_vote = {vote_ff[0], rxSync2_ff};
    case (rxSt_ff)
      RX_IDLE:
        if (cfg.receiveEnable && cfg.mode != 2'b00 && fallEdge)
        begin
          nxt_rxDiv  = 4'h0;
          nxt_rxBits = 4'h0;
          nxt_rxSt   = RX_FRAME;
        end
      RX_FRAME:
        if (rxTick && rxDiv_ff == 4'(uart_pkg::VOTE_LAST))
        begin
          nxt_rxBits  = rxBits_ff + 4'h1;
          nxt_rxShift = {bitVal, rxShift_ff[9:1]};
          if (rxBits_ff == 4'h0 && bitVal)
            nxt_rxSt = RX_IDLE;
          else if (rxBits_ff == frameBits - 4'h1)
          begin
            nxt_rxSt = RX_IDLE;
            if (!ri_ff && (!cfg.multiprocEnable
                || (ninth ? gotNinth : stopBit)))
            begin
              setRi    = 1'b1;
              nxt_serial_data_buffer = ninth ? rxShift_ff[8:1] : rxShift_ff[9:2];
              nxt_rb8  = ninth ? gotNinth : stopBit;
            end
          end
        end
      default:
        nxt_rxSt = RX_IDLE;
    endcase
    nxt_ri = setRi | (ri_ff & ~clearRxDone);
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rxSt_ff    <= RX_IDLE;
      rxDiv_ff   <= 4'h0;
      vote_ff    <= 2'h3;
      rxShift_ff <= 10'h000;
      rxBits_ff  <= 4'h0;
      serial_data_buffer_ff    <= 8'h00;
      rb8_ff     <= 1'b0;
      ri_ff      <= 1'b0;
    end
    else
    begin
      rxSt_ff    <= nxt_rxSt;
      rxDiv_ff   <= nxt_rxDiv;
      vote_ff    <= nxt_vote;
      rxShift_ff <= nxt_rxShift;
      rxBits_ff  <= nxt_rxBits;
      serial_data_buffer_ff    <= nxt_serial_data_buffer;
      rb8_ff     <= nxt_rb8;
      ri_ff      <= nxt_ri;
    end
  end

  assign txdPin           = txd_ff;
  assign serialDataBuffer = serial_data_buffer_ff;
  assign rxNinthBit       = rb8_ff;
  assign transmitDoneFlag = ti_ff;
  assign receiveDoneFlag  = ri_ff;
  assign serialIrq        = ti_ff | ri_ff;

  property p_irq_level;
    @(posedge core_clk) disable iff (!reset_n)
    serialIrq == (transmitDoneFlag | receiveDoneFlag);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("irq does not follow flags");

  property p_ri_hold;
    @(posedge core_clk) disable iff (!reset_n)
    ri_ff && !clearRxDone |=> ri_ff;
  endproperty
  a_ri_hold: assert property (p_ri_hold)
    else $error("rx flag cleared by hardware");

  property p_ti_hold;
    @(posedge core_clk) disable iff (!reset_n)
    ti_ff && !clearTxDone |=> ti_ff;
  endproperty
  a_ti_hold: assert property (p_ti_hold)
    else $error("tx flag cleared by hardware");

  property p_no_accept_when_full;
    @(posedge core_clk) disable iff (!reset_n)
    ri_ff && !clearRxDone |=> $stable(serial_data_buffer_ff);
  endproperty
  a_no_accept_when_full: assert property (p_no_accept_when_full)
    else $error("buffer overwritten while rx flag set");

  property p_mp_gate;
    @(posedge core_clk) disable iff (!reset_n)
    $rose(ri_ff) && cfg.multiprocEnable |-> rb8_ff;
  endproperty
  a_mp_gate: assert property (p_mp_gate)
    else $error("multiproc accepted ninth bit zero");

  property p_ti8_delay;
    @(posedge core_clk) disable iff (!reset_n)
    txSt_ff == TX_SHIFT && nxt_txSt == TX_DONE |=> ##2 ti_ff;
  endproperty
  a_ti8_delay: assert property (p_ti8_delay)
    else $error("tx flag not two cycles after stop");

  property p_start_low;
    @(posedge core_clk) disable iff (!reset_n)
    txSt_ff == TX_WAIT && txRoll |=> !txdPin;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("start bit not low");

  property p_idle_high;
    @(posedge core_clk) disable iff (!reset_n)
    txSt_ff == TX_IDLE |=> txdPin || txSt_ff != TX_IDLE;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("line not idle high");

  c_rx_accept: cover property (@(posedge core_clk) $rose(ri_ff));
  c_tx_done: cover property (@(posedge core_clk) $rose(ti_ff));
  c_false_start: cover property (@(posedge core_clk)
    rxSt_ff == RX_FRAME ##1 rxSt_ff == RX_IDLE && rxBits_ff == 4'h1);
endmodule

/* File: test/remote_serial_port.sv */
/*
  Remote serial port model: sends frames on demand, captures frames.
  Assumes the bench sets the bit length in core clocks and frame size.
*/
`timescale 1ns/10ps
module remote_serial_port
(
  input  wire logic        core_clk, // Shared clock
  input  wire logic        lineIn,   // From port transmit pin
  input  wire logic [15:0] bitClks,  // Clocks per bit
  input  wire logic        nineBit,  // Eleven-bit frames
  output logic             lineOut   // To port receive pin
);
  logic [8:0] rxBits;
  logic       rxStop;
  int         rxCount;

  initial
  begin
    lineOut = 1'b1;
    rxBits  = 9'h000;
    rxStop  = 1'b0;
    rxCount = 0;
  end

  // start, data LSB first, ninth, stop
  task automatic send(input logic [8:0] bits, input logic stopBit);
    int n;
    n = nineBit ? 9 : 8;
    @(negedge core_clk);
    lineOut = 1'b0;
    repeat (bitClks) @(negedge core_clk);
    for (int i = 0; i < n; i++)
    begin
      lineOut = bits[i];
      repeat (bitClks) @(negedge core_clk);
    end
    lineOut = stopBit;
    repeat (bitClks) @(negedge core_clk);
    lineOut = 1'b1;
  endtask

  // Short low pulse, then quiet long enough to be rejected
  task automatic glitch(input int clks);
    @(negedge core_clk);
    lineOut = 1'b0;
    repeat (clks) @(negedge core_clk);
    lineOut = 1'b1;
    repeat (2 * bitClks) @(negedge core_clk);
  endtask

  always
  begin
    @(negedge lineIn);
    repeat (bitClks / 2) @(negedge core_clk);
    for (int i = 0; i < 9; i++)
    begin
      if (i < 8 || nineBit)
      begin
        repeat (bitClks) @(negedge core_clk);
        rxBits[i] = lineIn;
      end
    end
    repeat (bitClks) @(negedge core_clk);
    rxStop  = lineIn;
    rxCount = rxCount + 1;
  end
endmodule

/* File: test/testbench.sv */
/*
  Self-checking bench for the asynchronous serial port, modes 1 to 3.
  Assumes the remote port model drives the receive pin.
*/
`timescale 1ns/10ps
module testbench;
  logic                   core_clk;
  logic                   reset_n;
  uart_pkg::uart_cfg_s    cfg;
  uart_pkg::uart_reload_s reload;
  logic                   t2Trig;
  logic                   bufWrite;
  logic [7:0]             bufWriteData;
  logic                   clearTxDone;
  logic                   clearRxDone;
  logic                   rxdPin;
  logic                   txdPin;
  logic [7:0]             serialDataBuffer;
  logic                   rxNinthBit;
  logic                   transmitDoneFlag;
  logic                   receiveDoneFlag;
  logic                   timer2OverflowFlag;
  logic                   serialIrq;
  logic [15:0]            bitClks;
  logic                   nineBit;
  int                     failures;
  int                     checked;
  int                     frames;

  async_serial_port i_dut
  (
    .core_clk           (core_clk),
    .reset_n            (reset_n),
    .cfg                (cfg),
    .reload             (reload),
    .timer2ExtTrigger   (t2Trig),
    .bufWrite           (bufWrite),
    .bufWriteData       (bufWriteData),
    .clearTxDone        (clearTxDone),
    .clearRxDone        (clearRxDone),
    .rxdPin             (rxdPin),
    .txdPin             (txdPin),
    .serialDataBuffer   (serialDataBuffer),
    .rxNinthBit         (rxNinthBit),
    .transmitDoneFlag   (transmitDoneFlag),
    .receiveDoneFlag    (receiveDoneFlag),
    .timer2OverflowFlag (timer2OverflowFlag),
    .serialIrq          (serialIrq)
  );

  remote_serial_port i_partner
  (
    .core_clk (core_clk),
    .lineIn   (txdPin),
    .bitClks  (bitClks),
    .nineBit  (nineBit),
    .lineOut  (rxdPin)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic checkBit(input string what, input logic e, input logic g);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic checkByte(input string what, input logic [7:0] e,
                           input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  // Bounded wait: 0 for transmit done, 1 for a captured frame
  task automatic waitFor(input int which);
    int n;
    n = 0;
    while (n < 40 * bitClks && (which == 0 ? transmitDoneFlag !== 1'b1
                                : i_partner.rxCount == frames))
    begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 40 * bitClks)
    begin
      failures++;
      $display("ERROR wait %0d expected event seen timeout", which);
      summarize;
    end
  endtask

  task automatic sendByte(input logic [7:0] d);
    @(negedge core_clk);
    bufWrite     = 1'b1;
    bufWriteData = d;
    @(negedge core_clk);
    bufWrite     = 1'b0;
  endtask

  task automatic clearFlags;
    @(negedge core_clk);
    clearTxDone = 1'b1;
    clearRxDone = 1'b1;
    @(negedge core_clk);
    clearTxDone = 1'b0;
    clearRxDone = 1'b0;
  endtask

  task automatic txCheck(input logic [7:0] d, input logic ninth);
    frames = i_partner.rxCount;
    sendByte(d);
    repeat (2 * bitClks) @(negedge core_clk);
    sendByte(~d);
    waitFor(0);
    checkBit("txd at done", 1'b1, txdPin);
    waitFor(1);
    checkByte("tx data", d, i_partner.rxBits[7:0]);
    if (nineBit)
      checkBit("tx ninth", ninth, i_partner.rxBits[8]);
    checkBit("tx stop", 1'b1, i_partner.rxStop);
    checkBit("irq", 1'b1, serialIrq);
    checkBit("tx done held", 1'b1, transmitDoneFlag);
    clearFlags;
    checkBit("irq clear", 1'b0, serialIrq);
  endtask

  task automatic t1Run(input logic div4, input logic dbl,
                       input logic [7:0] rel, input logic [15:0] bits);
    @(negedge core_clk);
    cfg.timer1Div4Select    = div4;
    cfg.baudDouble          = dbl;
    reload.timer1ReloadByte = rel;
    bitClks                 = bits;
    txCheck(rel ^ 8'h5c, 1'b0);
  endtask

  task automatic rxCheck(input logic [8:0] bits, input logic stopBit,
                         input logic acc, input logic [7:0] expD,
                         input logic expN);
    i_partner.send(bits, stopBit);
    repeat (4) @(negedge core_clk);
    checkBit("rx done", acc, receiveDoneFlag);
    checkByte("rx data", expD, serialDataBuffer);
    checkBit("rx ninth", expN, rxNinthBit);
  endtask

  initial
  begin
    reset_n      = 1'b0;
    cfg          = '0;
    reload       = '0;
    t2Trig       = 1'b0;
    bufWrite     = 1'b0;
    bufWriteData = 8'h00;
    clearTxDone  = 1'b0;
    clearRxDone  = 1'b0;
    bitClks      = 16'h0040;
    nineBit      = 1'b1;
    failures     = 0;
    checked      = 0;
    repeat (6) @(negedge core_clk);
    reset_n = 1'b1;
    @(negedge core_clk);
    checkBit("txd idle", 1'b1, txdPin);
    checkBit("irq idle", 1'b0, serialIrq);
    cfg.mode = uart_pkg::MODE_ASYNC9_FIXED;
    for (int i = 0; i < 2; i++)
    begin
      cfg.baudDouble = i[0];
      cfg.txNinthBit = ~i[0];
      bitClks        = i[0] ? 16'h0020 : 16'h0040;
      txCheck(8'ha5 ^ i[7:0], ~i[0]);
    end
    cfg.mode = uart_pkg::MODE_ASYNC8;
    nineBit  = 1'b0;
    reload.timer2ReloadHigh = 8'hff;
    reload.timer2ReloadLow  = 8'hfe;
    t1Run(1'b1, 1'b1, 8'hff, 16'h0040);
    t1Run(1'b1, 1'b0, 8'hff, 16'h0080);
    t1Run(1'b1, 1'b1, 8'hfe, 16'h0080);
    t1Run(1'b0, 1'b1, 8'hff, 16'h00c0);
    cfg.mode           = uart_pkg::MODE_ASYNC9_TIMER;
    cfg.txTimer2Select = 1'b1;
    nineBit            = 1'b1;
    t2Trig             = 1'b1;
    bitClks = 16'h0040;
    txCheck(8'h96, 1'b0);
    reload.timer2ReloadLow = 8'hff;
    bitClks = 16'h0020;
    txCheck(8'h69, 1'b0);
    checkBit("t2 flag", 1'b0, timer2OverflowFlag);
    t2Trig                  = 1'b0;
    cfg.mode                = uart_pkg::MODE_ASYNC8;
    cfg.txTimer2Select      = 1'b0;
    cfg.receiveEnable       = 1'b1;
    cfg.timer1Div4Select    = 1'b1;
    nineBit                 = 1'b0;
    bitClks                 = 16'h0040;
    rxCheck({1'b0, 8'h5a}, 1'b1, 1'b1, 8'h5a, 1'b1);
    rxCheck({1'b0, 8'h33}, 1'b1, 1'b1, 8'h5a, 1'b1);
    clearFlags;
    cfg.multiprocEnable = 1'b1;
    rxCheck({1'b0, 8'h66}, 1'b0, 1'b0, 8'h5a, 1'b1);
    i_partner.glitch(2);
    checkBit("false start", 1'b0, receiveDoneFlag);
    rxCheck({1'b0, 8'hc3}, 1'b1, 1'b1, 8'hc3, 1'b1);
    clearFlags;
    cfg.multiprocEnable = 1'b0;
    cfg.rxTimer2Select  = 1'b1;
    bitClks             = 16'h0020;
    rxCheck({1'b0, 8'h0f}, 1'b1, 1'b1, 8'h0f, 1'b1);
    clearFlags;
    cfg.mode            = uart_pkg::MODE_ASYNC9_FIXED;
    cfg.multiprocEnable = 1'b1;
    nineBit             = 1'b1;
    rxCheck({1'b0, 8'h11}, 1'b1, 1'b0, 8'h0f, 1'b1);
    rxCheck({1'b1, 8'h22}, 1'b1, 1'b1, 8'h22, 1'b1);
    clearFlags;
    cfg.mode            = uart_pkg::MODE_ASYNC9_TIMER;
    cfg.multiprocEnable = 1'b0;
    rxCheck({1'b0, 8'h44}, 1'b1, 1'b1, 8'h44, 1'b0);
    summarize;
  end
endmodule
